// File: verilog/sma_consts.vh
// constants for the sdo measurement access block
`ifndef SMA_CONSTS_VH
`define SMA_CONSTS_VH

// ----------------------------------------------------------------------
// object indices and sub-indices
// ----------------------------------------------------------------------
`define SMA_IDX_STARTUP     16'h1f80
`define SMA_IDX_PV_FLOAT    16'h6130
`define SMA_IDX_PV_SHORT    16'h7130
`define SMA_IDX_PV_LONG     16'h9130
`define SMA_SUB_ZERO        8'h00
`define SMA_SUB_PRIMARY     8'h01
`define SMA_SUB_SECONDARY   8'h02

// ----------------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------------
`define SMA_CMD_DL_4BYTE    8'h23
`define SMA_CMD_DL_ACK      8'h60
`define SMA_CMD_UPLOAD_REQ  8'h40
`define SMA_CMD_UPLOAD_4    8'h43
`define SMA_CMD_ABORT       8'h80

// ----------------------------------------------------------------------
// identifiers, behaviour values, abort codes
// ----------------------------------------------------------------------
`define SMA_COB_TX_BASE     11'h580
`define SMA_STARTUP_AUTO    8'h08
`define SMA_STARTUP_NONE    8'h00
`define SMA_ABT_BAD_CMD     32'h05040001
`define SMA_ABT_READ_ONLY   32'h06010002
`define SMA_ABT_NO_OBJECT   32'h06020000
`define SMA_ABT_BAD_VALUE   32'h06090030
`define SMA_ABT_NO_SUB      32'h06090011

// ----------------------------------------------------------------------
// measurement range defaults
// ----------------------------------------------------------------------
`define SMA_RANGE_DEFAULT   32'h00004e20
`define SMA_DEC_MAX         3'h4

`endif

// File: verilog/sma_pv_fmt.v
// process value integer formatting: scaling, decimal shift, clamping
module sma_pv_fmt #(
  parameter W = 32
) (
  input  wire signed [W-1:0] raw_i,
  input  wire                scale_en_i,
  input  wire signed [W-1:0] scale_min_i,
  input  wire signed [W-1:0] scale_max_i,
  input  wire [2:0]          dec_digits_i,
  input  wire                clamp_en_i,
  input  wire signed [W-1:0] clamp_min_i,
  input  wire signed [W-1:0] clamp_max_i,
  output reg  signed [W-1:0] value_o
);
`include "sma_consts.vh"

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function [15:0] pow10;
    input [2:0] d;
    begin
      case (d)
        3'h0:    pow10 = 16'h0001;
        3'h1:    pow10 = 16'h000a;
        3'h2:    pow10 = 16'h0064;
        3'h3:    pow10 = 16'h03e8;
        default: pow10 = 16'h2710;
      endcase
    end
  endfunction

  // ------------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------------
  reg signed [63:0] span;
  reg signed [63:0] scaled;
  reg signed [63:0] shifted;
  reg [2:0]         dec;

  always @* begin
    span    = 64'sh0;
    scaled  = 64'sh0;
    shifted = 64'sh0;
    dec     = (dec_digits_i > `SMA_DEC_MAX) ? `SMA_DEC_MAX : dec_digits_i;
    // linear map of 0..20000 onto min..max; divide by constant keeps it small
    if (scale_en_i) begin
      span   = $signed({{32{scale_max_i[W-1]}}, scale_max_i})
             - $signed({{32{scale_min_i[W-1]}}, scale_min_i});
      scaled = (span * $signed({{32{raw_i[W-1]}}, raw_i}))
             / $signed({32'h0, `SMA_RANGE_DEFAULT});
      scaled = scaled + $signed({{32{scale_min_i[W-1]}}, scale_min_i});
    end else begin
      scaled = $signed({{32{raw_i[W-1]}}, raw_i});
    end
    shifted = scaled * $signed({48'h0, pow10(dec)});
    value_o = shifted[W-1:0]; // two's complement result
    if (clamp_en_i) begin
      if (shifted < $signed({{32{clamp_min_i[W-1]}}, clamp_min_i}))
        value_o = clamp_min_i;
      else if (shifted > $signed({{32{clamp_max_i[W-1]}}, clamp_max_i}))
        value_o = clamp_max_i;
    end
  end

endmodule // sma_pv_fmt

// File: verilog/sma_sdo_resp.v
// expedited sdo responder for start-up behaviour and process value reads
// ----------------------------------------------------------------------
// Notes on behaviour
// - without autostart, stay pre-operational, no process data until commanded
// - value 0x08 enables autostart, 0x00 disables it
// - accepted write answered on 0x580 plus node, command 60, echo, zero data
// - changed start-up behaviour held volatile; store procedure makes it persist
// - multi-byte values sent lsb first or msb first, per byte-order setting
// - upload answered with command 43, echo, latest value in last four bytes
// - float32 is ieee single precision, lsb first in little-endian order
// - default range 0..20000 linear on physical range; scaling changes it
// - secondary channel on pressure parts always spans -55 to 125 degrees
// - int16 at 0x7130, int32 at 0x9130, same framing as float32 read
// - int16 fills two lower bytes, int32 all four, lsb first in little-endian order
// - integer values signed, negatives in two's complement
// - decimal digits setting shifts integer values; default zero, no shift
// - values optionally clamped to configured minimum and maximum; code clamps only int16 and int32 reads, float32 passes unclamped
// ----------------------------------------------------------------------
module sma_sdo_resp #(
  parameter HAS_SECONDARY = 1,
  parameter DEC_DEFAULT   = 3'h0
) (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire [6:0]  node_id_i,
  input  wire        req_valid_i,
  input  wire [63:0] req_data_i,
  input  wire        store_autostart_i,
  input  wire        nmt_start_i,
  input  wire        nmt_preop_i,
  input  wire        big_endian_i,
  input  wire [31:0] pri_float_i,
  input  wire [31:0] pri_raw_i,
  input  wire [31:0] sec_float_i,
  input  wire [31:0] sec_raw_i,
  input  wire        scale_en_i,
  input  wire [31:0] scale_min_i,
  input  wire [31:0] scale_max_i,
  input  wire        dec_wr_i,
  input  wire [2:0]  dec_digits_i,
  input  wire        clamp_en_i,
  input  wire [31:0] clamp_min_i,
  input  wire [31:0] clamp_max_i,
  output reg         rsp_valid_o,
  output reg  [10:0] rsp_cob_id_o,
  output reg  [63:0] rsp_data_o,
  output reg         autostart_o,
  output reg         operational_o,
  output reg         pdo_enable_o
);
`include "sma_consts.vh"

  // ------------------------------------------------------------------
  // state encoding
  // ------------------------------------------------------------------
  localparam [1:0] ST_BOOT   = 2'h0;
  localparam [1:0] ST_PREOP  = 2'h1;
  localparam [1:0] ST_OPER   = 2'h2;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function [31:0] swap32;
    input [31:0] v;
    begin
      swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
    end
  endfunction

  function [63:0] frame;
    input [7:0]  cmd;
    input [23:0] mux;
    input [31:0] data;
    begin
      frame = {data, mux, cmd};
    end
  endfunction

  // ------------------------------------------------------------------
  // request fields
  // ------------------------------------------------------------------
  wire [7:0]  req_cmd = req_data_i[7:0];
  wire [15:0] req_idx = req_data_i[23:8];
  wire [7:0]  req_sub = req_data_i[31:24];
  wire [7:0]  req_val = req_data_i[39:32];
  wire [23:0] req_mux = req_data_i[31:8];

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg        autostart_r;
  reg        autostart_nxt;
  reg [2:0]  dec_r;
  reg        rsp_valid_nxt;
  reg [10:0] rsp_cob_id_nxt;
  reg [63:0] rsp_data_nxt;

  // ------------------------------------------------------------------
  // channel select and integer formatting
  // ------------------------------------------------------------------
  wire        sel_sec = (req_sub == `SMA_SUB_SECONDARY);
  wire [31:0] raw_sel = sel_sec ? sec_raw_i : pri_raw_i;
  wire [31:0] flt_sel = sel_sec ? sec_float_i : pri_float_i;
  wire [31:0] int_val;

  // secondary range is fixed to the temperature span, so scaling is bypassed
  sma_pv_fmt #(
    .W            (32)
  ) u_fmt (
    .raw_i        (raw_sel),
    .scale_en_i   (scale_en_i & ~sel_sec),
    .scale_min_i  (scale_min_i),
    .scale_max_i  (scale_max_i),
    .dec_digits_i (dec_r),
    .clamp_en_i   (clamp_en_i),
    .clamp_min_i  (clamp_min_i),
    .clamp_max_i  (clamp_max_i),
    .value_o      (int_val)
  );

  // ------------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------------
  reg        idx_pv;
  reg        sub_ok;
  reg [31:0] payload;

  always @* begin
    idx_pv = (req_idx == `SMA_IDX_PV_FLOAT) || (req_idx == `SMA_IDX_PV_SHORT)
          || (req_idx == `SMA_IDX_PV_LONG);
    sub_ok = (req_sub == `SMA_SUB_PRIMARY)
          || ((req_sub == `SMA_SUB_SECONDARY) && (HAS_SECONDARY != 0));
    payload = 32'h0;
    if (req_idx == `SMA_IDX_PV_FLOAT) begin
      // float arrives in ieee single form, bytes laid out lsb first, or msb first via swap32 when big_endian_i is set
      payload = big_endian_i ? swap32(flt_sel) : flt_sel;
    end else if (req_idx == `SMA_IDX_PV_SHORT) begin
      // int16 in the two lower bytes, upper two zero
      payload = big_endian_i ? {16'h0, int_val[7:0], int_val[15:8]}
                             : {16'h0, int_val[15:0]};
    end else begin
      payload = big_endian_i ? swap32(int_val) : int_val;
    end
  end

  // ------------------------------------------------------------------
  // response and start-up behaviour
  // ------------------------------------------------------------------
  always @* begin
    rsp_valid_nxt  = 1'b0;
    rsp_cob_id_nxt = rsp_cob_id_o;
    rsp_data_nxt   = rsp_data_o;
    autostart_nxt  = autostart_r;
    if (state_r == ST_BOOT) begin
      // volatile copy reloaded from the stored setting at boot
      autostart_nxt = store_autostart_i;
    end else if (req_valid_i) begin
      rsp_valid_nxt  = 1'b1;
      rsp_cob_id_nxt = `SMA_COB_TX_BASE + {4'h0, node_id_i};
      rsp_data_nxt   = frame(`SMA_CMD_ABORT, req_mux, `SMA_ABT_NO_OBJECT);
      if (req_idx == `SMA_IDX_STARTUP) begin
        if (req_sub != `SMA_SUB_ZERO) begin
          rsp_data_nxt = frame(`SMA_CMD_ABORT, req_mux, `SMA_ABT_NO_SUB);
        end else if (req_cmd == `SMA_CMD_DL_4BYTE) begin
          if (req_val == `SMA_STARTUP_AUTO || req_val == `SMA_STARTUP_NONE) begin
            autostart_nxt = (req_val == `SMA_STARTUP_AUTO);
            rsp_data_nxt  = frame(`SMA_CMD_DL_ACK, req_mux, 32'h0);
          end else begin
            rsp_data_nxt = frame(`SMA_CMD_ABORT, req_mux, `SMA_ABT_BAD_VALUE);
          end
        end else if (req_cmd == `SMA_CMD_UPLOAD_REQ) begin
          rsp_data_nxt = frame(`SMA_CMD_UPLOAD_4, req_mux,
                               {24'h0, autostart_r ? `SMA_STARTUP_AUTO
                                                   : `SMA_STARTUP_NONE});
        end else begin
          rsp_data_nxt = frame(`SMA_CMD_ABORT, req_mux, `SMA_ABT_BAD_CMD);
        end
      end else if (idx_pv) begin
        if (!sub_ok) begin
          rsp_data_nxt = frame(`SMA_CMD_ABORT, req_mux, `SMA_ABT_NO_SUB);
        end else if (req_cmd == `SMA_CMD_UPLOAD_REQ) begin
          rsp_data_nxt = frame(`SMA_CMD_UPLOAD_4, req_mux, payload);
        end else if (req_cmd == `SMA_CMD_DL_4BYTE) begin
          rsp_data_nxt = frame(`SMA_CMD_ABORT, req_mux, `SMA_ABT_READ_ONLY);
        end else begin
          rsp_data_nxt = frame(`SMA_CMD_ABORT, req_mux, `SMA_ABT_BAD_CMD);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // network state
  // ------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_BOOT: begin
        // stay pre-operational unless autostart is set
        state_nxt = store_autostart_i ? ST_OPER : ST_PREOP;
      end
      ST_PREOP: begin
        if (nmt_start_i)
          state_nxt = ST_OPER;
      end
      ST_OPER: begin
        if (nmt_preop_i)
          state_nxt = ST_PREOP;
      end
      default: begin
        state_nxt = ST_BOOT;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // flip-flops
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_r       <= ST_BOOT;
      autostart_r   <= 1'b0;
      dec_r         <= DEC_DEFAULT;
      rsp_valid_o   <= 1'b0;
      rsp_cob_id_o  <= 11'h000;
      rsp_data_o    <= 64'h0;
      autostart_o   <= 1'b0;
      operational_o <= 1'b0;
      pdo_enable_o  <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      autostart_r   <= autostart_nxt;
      if (dec_wr_i)
        dec_r <= dec_digits_i;
      rsp_valid_o   <= rsp_valid_nxt;
      rsp_cob_id_o  <= rsp_cob_id_nxt;
      rsp_data_o    <= rsp_data_nxt;
      autostart_o   <= autostart_nxt;
      operational_o <= (state_nxt == ST_OPER);
      pdo_enable_o  <= (state_nxt == ST_OPER);
    end
  end

endmodule // sma_sdo_resp

// File: verif/sma_master_model.sv
// master model issuing expedited sdo requests toward the responder
module sma_master_model (
  input  wire logic        clk_sys_i,
  output logic             req_valid_o,
  output logic [63:0]      req_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // request driving
  // ----
  initial begin
    req_valid_o = 1'b0;
    req_data_o  = 64'h0;
  end
  // frame built by caller: command, index lsb first, sub, data
  task automatic send(input logic [63:0] f);
    @(negedge clk_sys_i);
    req_valid_o = 1'b1;
    req_data_o  = f;
  endtask
  // released bus shows inverted data, so no stale frame looks valid
  task automatic idle();
    @(negedge clk_sys_i);
    req_valid_o = 1'b0;
    req_data_o  = ~req_data_o;
  endtask
endmodule // sma_master_model

// File: verif/sma_sdo_resp_asserts.sv
// concurrent checks on the sdo responder ports
module sma_sdo_resp_asserts (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [6:0]  node_id_i,
  input wire logic        req_valid_i,
  input wire logic [63:0] req_data_i,
  input wire logic        nmt_start_i,
  input wire logic        big_endian_i,
  input wire logic [31:0] pri_float_i,
  input wire logic        rsp_valid_o,
  input wire logic [10:0] rsp_cob_id_o,
  input wire logic [63:0] rsp_data_o,
  input wire logic        autostart_o,
  input wire logic        operational_o,
  input wire logic        pdo_enable_o
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  resp_latency_a: assert property (req_valid_i && $past(rst_n_i) |=> rsp_valid_o)
    else $error("request not answered next cycle");
  resp_cause_a: assert property (rsp_valid_o |-> $past(req_valid_i))
    else $error("response without request");
  cob_base_a: assert property (rsp_valid_o |-> rsp_cob_id_o == 11'h580 + $past(node_id_i))
    else $error("response identifier wrong");
  echo_hdr_a: assert property (rsp_valid_o |-> rsp_data_o[31:8] == $past(req_data_i[31:8]))
    else $error("index or sub not echoed");
  pdo_gate_a: assert property (pdo_enable_o == operational_o)
    else $error("process data enabled outside operational");
  float_le_a: assert property (req_valid_i && $past(rst_n_i) && !big_endian_i
    && req_data_i[31:0] == 32'h01613040 |=> rsp_data_o == {$past(pri_float_i), 32'h01613043})
    else $error("float read payload wrong");
  abort_index_a: assert property (req_valid_i && $past(rst_n_i) && req_data_i[23:8] != 16'h1f80
    && req_data_i[23:8] != 16'h6130 && req_data_i[23:8] != 16'h7130 && req_data_i[23:8] != 16'h9130
    |=> rsp_data_o[7:0] == 8'h80 && rsp_data_o[63:32] == 32'h06020000)
    else $error("unknown index not aborted");
  preop_hold_a: assert property (!operational_o && !nmt_start_i && $past(rst_n_i)
    |=> !operational_o)
    else $error("left pre-operational uncommanded");
  autostart_set_a: assert property (req_valid_i && $past(rst_n_i)
    && req_data_i[39:0] == 40'h08001f8023 |=> autostart_o)
    else $error("autostart write not applied");
  cover property (rsp_valid_o && rsp_data_o[7:0] == 8'h80);
  cover property (autostart_o);
  cover property (operational_o);
endmodule // sma_sdo_resp_asserts

bind sma_sdo_resp sma_sdo_resp_asserts chk_u (.clk_sys_i, .rst_n_i, .node_id_i, .req_valid_i,
  .req_data_i, .nmt_start_i, .big_endian_i, .pri_float_i, .rsp_valid_o, .rsp_cob_id_o,
  .rsp_data_o, .autostart_o, .operational_o, .pdo_enable_o);

// File: verif/sdo_measurement_access_bench.sv
// self-checking bench for the sdo responder
module sdo_measurement_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // signals and model state
  // ----
  logic        clk_sys_i = 0, rst_n_i = 0, store_autostart_i = 0, nmt_start_i = 0;
  logic        nmt_preop_i = 0, big_endian_i = 0, dec_wr_i = 0, clamp_en_i = 0, req_valid_i;
  logic        scale_en_i = 0;
  logic [31:0] scale_min_i = 0, scale_max_i = 0;
  logic [31:0] pri_float_i = 0, pri_raw_i = 0, sec_float_i = 0, sec_raw_i = 0;
  logic [31:0] clamp_min_i = 0, clamp_max_i = 0, seed = 32'hd5e65956;
  logic [63:0] req_data_i, rsp_data_o;
  logic [6:0]  node_id_i = 7'h05;
  logic [2:0]  dec_digits_i = 0;
  logic [10:0] rsp_cob_id_o;
  logic        rsp_valid_o, autostart_o, operational_o, pdo_enable_o, auto_m = 0;
  int          n_mismatch = 0, n_compared = 0, dec_m = 0;
  logic [74:0] exp_q[$];
  logic [63:0] errs[5];
  sma_sdo_resp dut_u (.clk_sys_i, .rst_n_i, .node_id_i, .req_valid_i, .req_data_i,
    .store_autostart_i, .nmt_start_i, .nmt_preop_i, .big_endian_i, .pri_float_i, .pri_raw_i,
    .sec_float_i, .sec_raw_i, .scale_en_i, .scale_min_i, .scale_max_i,
    .dec_wr_i, .dec_digits_i, .clamp_en_i, .clamp_min_i, .clamp_max_i, .rsp_valid_o,
    .rsp_cob_id_o, .rsp_data_o, .autostart_o, .operational_o, .pdo_enable_o);
  sma_master_model mst_u (.clk_sys_i, .req_valid_o(req_valid_i), .req_data_o(req_data_i));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [63:0] frm(logic [7:0] c, logic [15:0] x, logic [7:0] s,
                                      logic [31:0] d);
    return {d, s, x, c};
  endfunction
  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_frame(input logic [74:0] e, input logic [74:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t frame exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_flag(input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t flag exp %b got %b", $time, e, g);
    end
  endtask
  // ----
  // reference model of the answer
  // ----
  task automatic tx(input logic [63:0] f);
    logic [7:0] c, s; logic [15:0] x; logic [23:0] h; logic [31:0] v, e; longint t; logic [63:0] r;
    c = f[7:0]; x = f[23:8]; s = f[31:24]; h = f[31:8]; e = 0;
    t = longint'($signed(s == 1 ? pri_raw_i : sec_raw_i));
    // secondary keeps its fixed temperature span, only primary is mapped
    if (scale_en_i && s == 1) t = longint'($signed(scale_min_i))
      + (longint'($signed(scale_max_i)) - longint'($signed(scale_min_i))) * t / 20000;
    repeat (dec_m > 4 ? 4 : dec_m) t = t * 10;
    if (clamp_en_i && t < $signed(clamp_min_i)) t = $signed(clamp_min_i);
    if (clamp_en_i && t > $signed(clamp_max_i)) t = $signed(clamp_max_i);
    v = x == 16'h6130 ? (s == 1 ? pri_float_i : sec_float_i) : t[31:0];
    if (x == 16'h7130) v = {16'h0, big_endian_i ? {v[7:0], v[15:8]} : v[15:0]};
    else if (big_endian_i) v = {v[7:0], v[15:8], v[23:16], v[31:24]};
    if (x == 16'h1f80) begin
      if (s != 0) e = 32'h06090011;
      else if (c == 8'h40) r = {24'h0, 4'h0, auto_m, 3'h0, h, 8'h43};
      else if (c != 8'h23) e = 32'h05040001;
      else if (f[39:32] != 8'h08 && f[39:32] != 8'h00) e = 32'h06090030;
      else begin r = {32'h0, h, 8'h60}; auto_m = f[35]; end
    end else if (x == 16'h6130 || x == 16'h7130 || x == 16'h9130) begin
      if (s != 1 && s != 2) e = 32'h06090011;
      else if (c == 8'h23) e = 32'h06010002;
      else if (c != 8'h40) e = 32'h05040001;
      else r = {v, h, 8'h43};
    end else e = 32'h06020000;
    if (e != 0) r = {e, h, 8'h80};
    exp_q.push_back({11'h580 + {4'h0, node_id_i}, r});
    mst_u.send(f);
  endtask
  always @(negedge clk_sys_i) if (rsp_valid_o === 1'b1) begin
    if (exp_q.size() != 0) cmp_frame(exp_q.pop_front(), {rsp_cob_id_o, rsp_data_o});
    else cmp_frame(~{rsp_cob_id_o, rsp_data_o}, {rsp_cob_id_o, rsp_data_o});
  end
  task automatic do_reset(input logic st);
    @(negedge clk_sys_i);
    rst_n_i = 0;
    store_autostart_i = st;
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1;
    auto_m = st;
    dec_m = 0;
    repeat (3) @(negedge clk_sys_i);
    cmp_flag(st, autostart_o);
    cmp_flag(st, operational_o);
    cmp_flag(st, pdo_enable_o);
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    errs = '{frm(8'h40, 16'h6130, 8'h03, 0), frm(8'h23, 16'h7130, 8'h01, 5),
             frm(8'h99, 16'h9130, 8'h01, 0), frm(8'h40, 16'h6131, 8'h01, 0),
             frm(8'h40, 16'h9130, 8'h00, 0)};
    do_reset(0);
    nmt_start_i = 1;
    @(negedge clk_sys_i) nmt_start_i = 0;
    @(negedge clk_sys_i) cmp_flag(1, pdo_enable_o);
    nmt_preop_i = 1;
    @(negedge clk_sys_i) nmt_preop_i = 0;
    @(negedge clk_sys_i) cmp_flag(0, operational_o);
    foreach (errs[k])
      tx(frm(8'h23, 16'h1f80, k == 2, k == 1 ? 8'h05 : k == 3 ? 8'h00 : 8'h08));
    tx(frm(8'h40, 16'h1f80, 0, 0));
    mst_u.idle();
    repeat (3) @(negedge clk_sys_i);
    cmp_flag(0, operational_o);
    cmp_flag(1, autostart_o);
    do_reset(0);
    do_reset(1);
    for (int i = 0; i < 40; i++) begin
      pri_raw_i = int'(rnd() % 40001) - 20000;
      sec_raw_i = int'(rnd() % 40001) - 20000;
      pri_float_i = rnd();
      sec_float_i = rnd();
      big_endian_i = rnd() & 1;
      clamp_en_i = rnd() & 1;
      clamp_min_i = -int'(rnd() % 3000);
      clamp_max_i = rnd() % 900000;
      scale_en_i = rnd() & 1;
      scale_min_i = -int'(rnd() % 1000);
      scale_max_i = rnd() % 100000;
      dec_digits_i = rnd() % 8;
      dec_wr_i = 1;
      dec_m = dec_digits_i;
      @(negedge clk_sys_i) dec_wr_i = 0;
      foreach (errs[k]) if (k < 3) begin
        tx(frm(8'h40, k == 0 ? 16'h6130 : k == 1 ? 16'h7130 : 16'h9130, 1, 0));
        tx(frm(8'h40, k == 0 ? 16'h6130 : k == 1 ? 16'h7130 : 16'h9130, 2, 0));
      end
      tx(errs[i % 5]);
      mst_u.idle();
      repeat (3) @(negedge clk_sys_i);
    end
    cmp_flag(0, exp_q.size() != 0);
    stop_test();
  end
  initial begin
    #100us;
    n_mismatch++;
    stop_test();
  end
endmodule // sdo_measurement_access_bench
